// [iep_ctrl.sv]
// Interrupt enable and priority registers with request flags and core arbitration.
// Assumes peripheral requests and external enables arrive on aclk; AXI4-Lite slave.
//
// The implementer's own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "iep_regs.svh"
module iep_ctrl
  import iep_pkg::*;
#(
  parameter logic [2:0] FIXED_PRIO = 3'h4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [19:0] irq_req,
  input wire logic [10:0] prio_src_en,
  output logic irq,
  output iep_core_req_t core_req
);
  localparam int NSRC = 20;

  logic [15:0] en3_r, en4_r, en5_r;
  logic [15:0] pr0_r, pr1_r, pr2_r;
  logic [19:0] flag_r, mask_r;
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [7:0] waddr_r;
  logic [31:0] wdata_r, rdata_r;
  logic [3:0] wstrb_r;
  logic [1:0] bresp_r, rresp_r;
  iep_core_req_t core_r;
  logic wr_go, wr_hit, rd_take, rd_hit, rd_clr;
  logic [31:0] rd_word, wbm;
  logic [19:0] en_vec;
  logic [2:0] prio_vec [NSRC];
  logic [2:0] lvl [NSRC];
  logic [3*NSRC-1:0] prio_flat;
  logic [2:0] best_lvl;
  logic [4:0] best_src;

  function automatic logic [15:0] upd16(input logic [15:0] old, input logic [15:0] lay);
    upd16 = ((old & ~wbm[15:0]) | (wdata_r[15:0] & wbm[15:0])) & lay;
  endfunction : upd16

  assign awready = !aw_hold_r;
  assign wready = !w_hold_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = !rvalid_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign core_req = core_r;
  assign wbm = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};
  // Write waits for both halves and for the previous response to drain
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign rd_take = arvalid && !rvalid_r;
  assign rd_clr = rd_take && (araddr == `IEP_OFF_STAT);

  // Address and data channels are taken independently, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      waddr_r <= 8'h00;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else begin
      if (awvalid && !aw_hold_r) begin
        aw_hold_r <= 1'b1;
        waddr_r <= awaddr;
      end else if (wr_go) begin
        aw_hold_r <= 1'b0;
      end
      if (wvalid && !w_hold_r) begin
        w_hold_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end else if (wr_go) begin
        w_hold_r <= 1'b0;
      end
    end
  end

  always_comb begin
    unique case (waddr_r)
      `IEP_OFF_EN3, `IEP_OFF_EN4, `IEP_OFF_EN5, `IEP_OFF_PR0, `IEP_OFF_PR1,
      `IEP_OFF_PR2, `IEP_OFF_MASK: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= `IEP_RESP_OKAY;
    end else if (wr_go) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_hit ? `IEP_RESP_OKAY : `IEP_RESP_SLVERR;
    end else if (bready) begin
      bvalid_r <= 1'b0;
    end
  end

  // Enable registers; unimplemented positions are masked off on write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // [R11] enables start cleared
      en3_r <= `IEP_RST_EN;
      en4_r <= `IEP_RST_EN;
      en5_r <= `IEP_RST_EN;
    end else if (wr_go) begin
      // [R1] [R2] [R12] group three layout
      if (waddr_r == `IEP_OFF_EN3) en3_r <= upd16(en3_r, `IEP_LAY_EN3);
      // [R3] [R4] group four layout
      if (waddr_r == `IEP_OFF_EN4) en4_r <= upd16(en4_r, `IEP_LAY_EN4);
      // [R5] group five layout
      if (waddr_r == `IEP_OFF_EN5) en5_r <= upd16(en5_r, `IEP_LAY_EN5);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      // [R10] fields start at binary 100
      pr0_r <= `IEP_RST_PR0;
      pr1_r <= `IEP_RST_PR1;
      pr2_r <= `IEP_RST_PR2;
    end else if (wr_go) begin
      // [R13] [R12] group zero fields
      if (waddr_r == `IEP_OFF_PR0) pr0_r <= upd16(pr0_r, `IEP_LAY_PR0);
      // [R14] group one fields
      if (waddr_r == `IEP_OFF_PR1) pr1_r <= upd16(pr1_r, `IEP_LAY_PR1);
      // [R15] group two fields
      if (waddr_r == `IEP_OFF_PR2) pr2_r <= upd16(pr2_r, `IEP_LAY_PR2);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= 20'h00000;
    end else if (wr_go && waddr_r == `IEP_OFF_MASK) begin
      mask_r <= (mask_r & ~wbm[19:0]) | (wdata_r[19:0] & wbm[19:0]);
    end
  end

  // [R16] sticky flags; a request in the clearing cycle survives
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_r <= 20'h00000;
    end else if (rd_clr) begin
      flag_r <= irq_req;
    end else begin
      flag_r <= flag_r | irq_req;
    end
  end

  assign irq = |(flag_r & mask_r);

  always_comb begin
    rd_hit = 1'b1;
    unique case (araddr)
      `IEP_OFF_EN3: rd_word = {16'h0000, en3_r};
      `IEP_OFF_EN4: rd_word = {16'h0000, en4_r};
      `IEP_OFF_EN5: rd_word = {16'h0000, en5_r};
      `IEP_OFF_PR0: rd_word = {16'h0000, pr0_r};
      `IEP_OFF_PR1: rd_word = {16'h0000, pr1_r};
      `IEP_OFF_PR2: rd_word = {16'h0000, pr2_r};
      `IEP_OFF_STAT: rd_word = {12'h000, flag_r};
      `IEP_OFF_MASK: rd_word = {12'h000, mask_r};
      `IEP_OFF_VEC: rd_word = {23'h000000, core_r};
      default: begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `IEP_RESP_OKAY;
    end else if (rd_take) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_word;
      rresp_r <= rd_hit ? `IEP_RESP_OKAY : `IEP_RESP_SLVERR;
    end else if (rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Sources 0-10 take their enable from elsewhere; 11-19 use a fixed level
  assign en_vec = {en5_r[`IEP_B_USB], en4_r[`IEP_B_SAERR], en4_r[`IEP_B_SBERR],
                   en4_r[`IEP_B_CRC], en4_r[`IEP_B_LVD], en4_r[`IEP_B_CTM],
                   en3_r[`IEP_B_I2CS], en3_r[`IEP_B_I2CM], en3_r[`IEP_B_CAL], prio_src_en};

  always_comb begin
    prio_vec[0] = pr0_r[`IEP_F3 +: 3];
    prio_vec[1] = pr0_r[`IEP_F2 +: 3];
    prio_vec[2] = pr0_r[`IEP_F1 +: 3];
    prio_vec[3] = pr0_r[`IEP_F0 +: 3];
    prio_vec[4] = pr1_r[`IEP_F3 +: 3];
    prio_vec[5] = pr1_r[`IEP_F2 +: 3];
    prio_vec[6] = pr1_r[`IEP_F1 +: 3];
    prio_vec[7] = pr2_r[`IEP_F3 +: 3];
    prio_vec[8] = pr2_r[`IEP_F2 +: 3];
    prio_vec[9] = pr2_r[`IEP_F1 +: 3];
    prio_vec[10] = pr2_r[`IEP_F0 +: 3];
    for (int k = 11; k < NSRC; k++) begin
      prio_vec[k] = FIXED_PRIO;
    end
  end

  for (genvar g = 0; g < NSRC; g++) begin : g_qual
    // Flat copy so an assertion can index the past fields by the current winner
    assign prio_flat[3*g +: 3] = prio_vec[g];
    iep_src_qual u_qual (
      .req_flag(flag_r[g]),
      .enable(en_vec[g]),
      .prio(prio_vec[g]),
      .level(lvl[g])
    );
  end

  // [R7] [R8] [R17] numeric compare; scanning down with >= lets lowest index win
  always_comb begin
    best_lvl = 3'h0;
    best_src = 5'h00;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (lvl[i] != 3'h0 && lvl[i] >= best_lvl) begin
        best_lvl = lvl[i];
        best_src = 5'(i);
      end
    end
  end

  // Registered so the core sees a glitch-free vector, one cycle behind the flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_r <= '0;
    end else begin
      core_r.valid <= (best_lvl != 3'h0);
      core_r.level <= best_lvl;
      core_r.src <= best_src;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  en3_layout_a: assert property (en3_r[15] == 1'b0 && en3_r[13:3] == 11'h000 && !en3_r[0]) // [R1]
    else $error("group three holds an unimplemented bit");
  en45_layout_a: assert property ((en4_r & ~`IEP_LAY_EN4) == 16'h0000 && en5_r[15:7] == 9'h000) // [R5]
    else $error("group four or five holds an unimplemented bit");
  prio_gaps_a: assert property (pr0_r[15] == 1'b0 && pr1_r[3:0] == 4'h0 && pr2_r[11] == 1'b0) // [R12]
    else $error("priority register holds an unimplemented bit");
  reset_vals_a: assert property (disable iff (1'b0) !aresetn |=> // [R10]
    pr0_r == `IEP_RST_PR0 && pr1_r == `IEP_RST_PR1 && en4_r == `IEP_RST_EN)
    else $error("reset values wrong");
  flag_sticky_a: assert property (irq_req != 20'h00000 |=> // [R16]
    (flag_r & $past(irq_req)) == $past(irq_req))
    else $error("request not captured in flag");
  disabled_src_a: assert property (core_r.valid |-> // [R6]
    (($past(en_vec & flag_r) >> core_r.src) & 20'h00001) != 20'h00000)
    else $error("core sees a disabled or unflagged source");
  zero_prio_a: assert property (core_r.valid |-> core_r.level != 3'h0 && // [R9]
    core_r.level == 3'($past(prio_flat) >> (3 * core_r.src)))
    else $error("core level does not match the source field");
  any_request_a: assert property ($past(best_lvl) != 3'h0 && $past(aresetn) |-> core_r.valid) // [R17]
    else $error("eligible source not presented");
  write_resp_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) // AXI4-Lite response held until bready
    else $error("write response dropped before bready");
endmodule : iep_ctrl
`default_nettype wire

// [iep_regs.svh]
// Register map, field positions and reset values of the interrupt enable/priority block.
// Assumes a 32-bit AXI4-Lite slave with byte addresses in the low 8 bits.
// Overview of operation
// [R1] Calendar enable at bit 14, group three
// [R2] Second I2C master bit 2, slave bit 1
// [R3] Charge-time enable bit 13, low-voltage bit 8
// [R4] Checksum bit 3, serial errors bits 2, 1
// [R5] Group five holds only the USB enable, bit 6
// [R6] Enable one forwards request, zero blocks it
// [R7] Code 111 is level 7, highest
// [R8] Code 001 is level 1, lowest active
// [R9] Code 000 disables the source completely; the code only keeps it off core_req, irq still follows flag and mask
// [R10] Priority fields reset to binary 100
// [R11] Enable bits reset to zero
// [R12] Unimplemented bits ignore writes, read zero
// [R13] Group zero: timer, compare, capture, external fields
// [R14] Group one: timer, compare, capture; low nibble empty
// [R15] Group two: receiver, spi event, fault, timer
// [R16] Flag reads one once request has occurred
// [R17] Highest level wins, lowest index breaks ties
`ifndef IEP_REGS_SVH
`define IEP_REGS_SVH
`define IEP_OFF_EN3 8'h00
`define IEP_OFF_EN4 8'h04
`define IEP_OFF_EN5 8'h08
`define IEP_OFF_PR0 8'h0C
`define IEP_OFF_PR1 8'h10
`define IEP_OFF_PR2 8'h14
`define IEP_OFF_STAT 8'h18
`define IEP_OFF_MASK 8'h1C
`define IEP_OFF_VEC 8'h20
`define IEP_LAY_EN3 16'h4006
`define IEP_LAY_EN4 16'h210E
`define IEP_LAY_EN5 16'h0040
`define IEP_LAY_PR0 16'h7777
`define IEP_LAY_PR1 16'h7770
`define IEP_LAY_PR2 16'h7777
`define IEP_RST_EN 16'h0000
`define IEP_RST_PR0 16'h4444
`define IEP_RST_PR1 16'h4440
`define IEP_RST_PR2 16'h4444
`define IEP_B_CAL 14
`define IEP_B_I2CM 2
`define IEP_B_I2CS 1
`define IEP_B_CTM 13
`define IEP_B_LVD 8
`define IEP_B_CRC 3
`define IEP_B_SBERR 2
`define IEP_B_SAERR 1
`define IEP_B_USB 6
`define IEP_F3 12
`define IEP_F2 8
`define IEP_F1 4
`define IEP_F0 0
`define IEP_RESP_OKAY 2'h0
`define IEP_RESP_SLVERR 2'h2
`endif

// [iep_pkg.sv]
// Types shared by the interrupt enable/priority block.
// Assumes nothing beyond a SystemVerilog compiler.
package iep_pkg;
  typedef struct packed {
    logic valid;
    logic [2:0] level;
    logic [4:0] src;
  } iep_core_req_t;
endpackage : iep_pkg

// [iep_src_qual.sv]
// Per-source qualifier: turns flag, enable and priority into a request level.
// Assumes all inputs come from flip-flops on the same clock.
`timescale 1ns/1ps
`default_nettype none
module iep_src_qual (
  input wire logic req_flag,
  input wire logic enable,
  input wire logic [2:0] prio,
  output logic [2:0] level
);
  // [R6] [R9] Enable and zero code gate the source
  assign level = (req_flag && enable) ? prio : 3'h0;
endmodule : iep_src_qual
`default_nettype wire

// [iep_src_model.sv]
// Model of the peripheral request sources facing the interrupt block.
// Assumes the bench gives a source vector and a one-cycle go strobe on aclk.
`timescale 1ns/1ps
`default_nettype none
module iep_src_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic go,
  input wire logic [19:0] fire,
  output logic [19:0] irq_req
);
  // One-cycle pulses only, so every flag check depends on the flag being sticky
  always_ff @(posedge aclk) begin
    if (!aresetn || !go) begin
      irq_req <= 20'h00000;
    end else begin
      irq_req <= fire;
    end
  end
endmodule : iep_src_model
`default_nettype wire

// [iep_ctrl_tb_top.sv]
// Bench for the interrupt enable/priority block: register table, arbitration, irq.
// Assumes the package, the register header, the design and the source model.
`timescale 1ns/1ps
`default_nettype none
`include "iep_regs.svh"
module iep_ctrl_tb_top
  import iep_pkg::*;
;
  typedef struct packed {logic [7:0] a; logic [31:0] rst; logic [31:0] lay;} iep_row_t;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic go = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'hF;
  logic [19:0] fire = 20'h0;
  logic [10:0] prio_src_en = 11'h7FF;
  logic [19:0] irq_req;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, got;
  iep_core_req_t core_req;
  int failures = 0;
  int checked = 0;
  iep_row_t rows [6] = '{'{`IEP_OFF_EN3, 32'h0, 32'h4006}, '{`IEP_OFF_EN4, 32'h0, 32'h210E},
    '{`IEP_OFF_EN5, 32'h0, 32'h0040}, '{`IEP_OFF_PR0, 32'h4444, 32'h7777},
    '{`IEP_OFF_PR1, 32'h4440, 32'h7770}, '{`IEP_OFF_PR2, 32'h4444, 32'h7777}};

  initial begin
    forever #2.5 aclk = ~aclk;
  end

  iep_ctrl dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
    .rvalid, .rready, .irq_req, .prio_src_en, .irq, .core_req);
  iep_src_model src (.aclk, .aresetn, .go, .fire, .irq_req);

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge aclk);
  endtask : tick

  // A missing answer ends the run instead of hanging it
  task automatic hang(input logic ok);
    if (ok !== 1'b1) begin
      failures++;
      close_out();
    end
  endtask : hang

  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    r = bresp;
    hang(bvalid);
    bready <= 1'b0;
    @(posedge aclk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    d = rdata;
    r = rresp;
    hang(rvalid);
    rready <= 1'b0;
    @(posedge aclk);
  endtask : rd

  // Pulse sources, check the winner and irq, then clear by reading status
  task automatic scen(input logic [19:0] v, input logic [8:0] ec, input logic ei);
    fire <= v;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    tick(4);
    chk("core_req", {23'h0, ec}, {23'h0, core_req});
    chk("irq", {31'h0, ei}, {31'h0, irq});
    rd(`IEP_OFF_VEC, got, resp);
    chk("vector", {23'h0, ec}, got);
    rd(`IEP_OFF_STAT, got, resp);
    chk("status", {12'h0, v}, got);
    tick(2);
    chk("idle_req", 32'h0, {23'h0, core_req});
    chk("irq_clr", 32'h0, {31'h0, irq});
  endtask : scen

  initial begin
    tick(5);
    aresetn <= 1'b1;
    foreach (rows[i]) begin
      rd(rows[i].a, got, resp);
      chk("reset_val", rows[i].rst, got);
      wr(rows[i].a, 32'hFFFF_FFFF, resp);
      chk("wr_resp", 32'h0, {30'h0, resp});
      rd(rows[i].a, got, resp);
      chk("layout", rows[i].lay, got);
    end
    wr(8'h24, 32'h1, resp);
    chk("unmapped_wr", 32'h2, {30'h0, resp});
    rd(8'h24, got, resp);
    chk("unmapped_rd", 32'h2, {30'h0, resp});
    chk("unmapped_data", 32'h0, got);
    wr(`IEP_OFF_STAT, 32'hFFFFF, resp);
    chk("ro_wr", 32'h2, {30'h0, resp});
    wr(`IEP_OFF_MASK, 32'h80000, resp);
    rd(`IEP_OFF_MASK, got, resp);
    chk("mask", 32'h80000, got);
    wr(`IEP_OFF_PR0, 32'h0170, resp);
    scen(20'h0000F, {1'b1, 3'h7, 5'h02}, 1'b0);
    scen(20'h00009, 9'h000, 1'b0);
    scen(20'h00003, {1'b1, 3'h1, 5'h01}, 1'b0);
    scen(20'h01800, {1'b1, 3'h4, 5'h0B}, 1'b0);
    scen(20'h80000, {1'b1, 3'h4, 5'h13}, 1'b1);
    scen(20'h40000, {1'b1, 3'h4, 5'h12}, 1'b0);
    wr(`IEP_OFF_EN3, 32'h0, resp);
    prio_src_en <= 11'h7FB;
    scen(20'h00804, 9'h000, 1'b0);
    // Byte lanes: only the low byte of group two takes the write
    wstrb <= 4'h1;
    wr(`IEP_OFF_PR2, 32'h0, resp);
    wstrb <= 4'hF;
    rd(`IEP_OFF_PR2, got, resp);
    chk("lane_wr", 32'h7700, got);
    // Reset in mid-run must restore the power-on values
    aresetn <= 1'b0;
    tick(2);
    aresetn <= 1'b1;
    rd(`IEP_OFF_PR0, got, resp);
    chk("rst_again", 32'h4444, got);
    rd(`IEP_OFF_EN4, got, resp);
    chk("rst_again", 32'h0, got);
    close_out();
  end
endmodule : iep_ctrl_tb_top
`default_nettype wire
